// >>> hdl/pmc_defines.svh
// register offsets, field positions and reset values of the pwm master control block
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

`define PMC_OFF_CTL 6'h00
`define PMC_OFF_SYNC 6'h04
`define PMC_OFF_ENABLE 6'h08
`define PMC_OFF_INVERT 6'h0c
`define PMC_OFF_FAULT 6'h10
`define PMC_OFF_INTEN 6'h14
`define PMC_OFF_RIS 6'h18
`define PMC_OFF_ISC 6'h1c
`define PMC_OFF_STATUS 6'h20

`define PMC_BIT_COMMIT 0
`define PMC_BIT_RESYNC 0
`define PMC_BIT_OUT_A 0
`define PMC_BIT_OUT_B 1
`define PMC_BIT_GEN_INT 0
`define PMC_BIT_FAULT_INT 16
`define PMC_BIT_FAULT_IN 0

`define PMC_RST_BIT 1'h0
`define PMC_RST_PAIR 2'h0
`define PMC_RST_WORD 32'h0000_0000

`endif

// >>> hdl/pmc_pkg.sv
// types shared by the pwm master control block
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_IDLE = 2'b00,
    PMC_ACK = 2'b01
  } pmc_bus_e;
endpackage

// >>> hdl/pmc_master_ctrl.sv
// pwm module master control: commit, resync, output conditioning and interrupt summary
`timescale 1ns/1ps
`include "pmc_defines.svh"

module pmc_master_ctrl (
  input wire logic clk_i, // 200 mhz system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [5:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic wb_err_o, // wishbone error on unmapped address
  input wire logic fault_pin_i, // external fault pin, async
  input wire logic debug_stall_i, // debugger stall, same clock
  input wire logic waveform_a_i, // raw waveform a from generator
  input wire logic waveform_b_i, // raw waveform b from generator
  input wire logic generator_int_i, // generator interrupt state
  input wire logic counter_zero_i, // generator counter at zero
  output logic commit_apply_o, // apply queued updates this cycle
  output logic counter_reset_o, // reset generator counter this cycle
  output logic fault_cond_o, // fault condition to generator
  output logic waveform_out_a_o, // conditioned pin a
  output logic waveform_out_b_o, // conditioned pin b
  output logic module_int_o // interrupt to controller
);

  // ----------------------------------------------------------------
  // fault pin synchroniser
  // ----------------------------------------------------------------
  logic fault_meta_q;
  logic fault_sync_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_meta_q <= `PMC_RST_BIT;
      fault_sync_q <= `PMC_RST_BIT;
    end else begin
      fault_meta_q <= fault_pin_i;
      fault_sync_q <= fault_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  pmc_pkg::pmc_bus_e bus_q;
  logic [31:0] rdata_d;
  logic hit_d;
  wire req_w = wb_cyc_i & wb_stb_i & (bus_q == pmc_pkg::PMC_IDLE);
  wire wr_w = req_w & wb_we_i & hit_d;
  wire [5:0] off_w = {wb_adr_i[5:2], 2'b00};
  wire lane0_w = wb_sel_i[0];
  wire lane2_w = wb_sel_i[2];
  wire wr_ctl_w = wr_w & (off_w == `PMC_OFF_CTL) & lane0_w;
  wire wr_sync_w = wr_w & (off_w == `PMC_OFF_SYNC) & lane0_w;
  wire wr_en_w = wr_w & (off_w == `PMC_OFF_ENABLE) & lane0_w;
  wire wr_inv_w = wr_w & (off_w == `PMC_OFF_INVERT) & lane0_w;
  wire wr_flt_w = wr_w & (off_w == `PMC_OFF_FAULT) & lane0_w;
  wire wr_ie_w = wr_w & (off_w == `PMC_OFF_INTEN);
  wire wr_isc_w = wr_w & (off_w == `PMC_OFF_ISC) & lane2_w;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic commit_q;
  logic resync_q;
  logic [1:0] enable_q;
  logic [1:0] invert_q;
  logic [1:0] force_q;
  logic ie_fault_q;
  logic ie_gen_q;
  logic fault_int_q;

  wire commit_fire_w = commit_q & counter_zero_i;
  wire fault_cond_w = fault_sync_q | debug_stall_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      commit_q <= `PMC_RST_BIT;
    end else if (wr_ctl_w & wb_dat_i[`PMC_BIT_COMMIT]) begin
      commit_q <= 1'b1;
    end else if (commit_fire_w) begin
      commit_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resync_q <= `PMC_RST_BIT;
    end else if (wr_sync_w & wb_dat_i[`PMC_BIT_RESYNC]) begin
      resync_q <= 1'b1;
    end else begin
      resync_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= `PMC_RST_PAIR;
      invert_q <= `PMC_RST_PAIR;
      force_q <= `PMC_RST_PAIR;
      ie_fault_q <= `PMC_RST_BIT;
      ie_gen_q <= `PMC_RST_BIT;
    end else begin
      if (wr_en_w) enable_q <= wb_dat_i[1:0];
      if (wr_inv_w) invert_q <= wb_dat_i[1:0];
      if (wr_flt_w) force_q <= wb_dat_i[1:0];
      if (wr_ie_w & lane2_w) ie_fault_q <= wb_dat_i[`PMC_BIT_FAULT_INT];
      if (wr_ie_w & lane0_w) ie_gen_q <= wb_dat_i[`PMC_BIT_GEN_INT];
    end
  end

  // latch fault, set wins over clear
  wire fault_clr_w = wr_isc_w & wb_dat_i[`PMC_BIT_FAULT_INT];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_int_q <= `PMC_RST_BIT;
    end else if (fault_sync_q) begin
      fault_int_q <= 1'b1;
    end else if (fault_clr_w) begin
      fault_int_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output conditioning
  // ----------------------------------------------------------------
  function automatic logic cond_out(input logic wave, input logic en, input logic frc,
                                    input logic inv, input logic flt);
    logic gated;
    logic forced;
    begin
      gated = wave & en;
      forced = gated & ~(frc & flt);
      cond_out = forced ^ inv;
    end
  endfunction

  wire pin_a_d = cond_out(waveform_a_i, enable_q[`PMC_BIT_OUT_A], force_q[`PMC_BIT_OUT_A],
                          invert_q[`PMC_BIT_OUT_A], fault_cond_w);
  wire pin_b_d = cond_out(waveform_b_i, enable_q[`PMC_BIT_OUT_B], force_q[`PMC_BIT_OUT_B],
                          invert_q[`PMC_BIT_OUT_B], fault_cond_w);

  wire int_d = (fault_int_q & ie_fault_q) | (generator_int_i & ie_gen_q);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = `PMC_RST_WORD;
    hit_d = 1'b1;
    case (off_w)
      `PMC_OFF_CTL: rdata_d[`PMC_BIT_COMMIT] = commit_q;
      `PMC_OFF_SYNC: rdata_d[`PMC_BIT_RESYNC] = resync_q;
      `PMC_OFF_ENABLE: rdata_d[1:0] = enable_q;
      `PMC_OFF_INVERT: rdata_d[1:0] = invert_q;
      `PMC_OFF_FAULT: rdata_d[1:0] = force_q;
      `PMC_OFF_INTEN: begin
        rdata_d[`PMC_BIT_FAULT_INT] = ie_fault_q;
        rdata_d[`PMC_BIT_GEN_INT] = ie_gen_q;
      end
      `PMC_OFF_RIS: begin
        rdata_d[`PMC_BIT_FAULT_INT] = fault_int_q;
        rdata_d[`PMC_BIT_GEN_INT] = generator_int_i;
      end
      `PMC_OFF_ISC: begin
        rdata_d[`PMC_BIT_FAULT_INT] = fault_int_q & ie_fault_q;
        rdata_d[`PMC_BIT_GEN_INT] = generator_int_i & ie_gen_q;
      end
      `PMC_OFF_STATUS: rdata_d[`PMC_BIT_FAULT_IN] = fault_sync_q;
      default: hit_d = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // bus answer and registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= pmc_pkg::PMC_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= `PMC_RST_WORD;
    end else begin
      case (bus_q)
        pmc_pkg::PMC_IDLE: begin
          wb_ack_o <= req_w & hit_d;
          wb_err_o <= req_w & ~hit_d;
          wb_dat_o <= rdata_d;
          if (req_w) bus_q <= pmc_pkg::PMC_ACK;
        end
        pmc_pkg::PMC_ACK: begin
          wb_ack_o <= 1'b0;
          wb_err_o <= 1'b0;
          bus_q <= pmc_pkg::PMC_IDLE;
        end
        default: bus_q <= pmc_pkg::PMC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      commit_apply_o <= 1'b0;
      counter_reset_o <= 1'b0;
      fault_cond_o <= 1'b0;
      waveform_out_a_o <= 1'b0;
      waveform_out_b_o <= 1'b0;
      module_int_o <= 1'b0;
    end else begin
      commit_apply_o <= commit_fire_w;
      counter_reset_o <= wr_sync_w & wb_dat_i[`PMC_BIT_RESYNC];
      fault_cond_o <= fault_cond_w;
      waveform_out_a_o <= pin_a_d;
      waveform_out_b_o <= pin_b_d;
      module_int_o <= int_d;
    end
  end

endmodule

// >>> tb/pmc_gen_model.sv
// behavioural generator model on the far side of the control block
`timescale 1ns/1ps
module pmc_gen_model (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic run_i, // counter runs when high
  input wire logic counter_reset_i, // resync pulse
  input wire logic int_req_i, // interrupt request
  output logic wave_a_o, // raw waveform a
  output logic wave_b_o, // raw waveform b
  output logic zero_o, // counter at zero
  output logic int_o // interrupt level
);
  logic [1:0] cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || counter_reset_i) cnt_q <= 2'h0;
    else if (run_i) cnt_q <= cnt_q - 2'h1;
  end
  assign zero_o = cnt_q == 2'h0;
  assign wave_a_o = cnt_q[1];
  assign wave_b_o = cnt_q < 2'h2;
  assign int_o = int_req_i;
endmodule

// >>> tb/pmc_master_ctrl_asserts.sv
// concurrent checks on the master control block ports
`timescale 1ns/1ps
module pmc_ctrl_chk (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [5:0] wb_adr_i, // address
  input wire logic wb_ack_o, // ack
  input wire logic wb_err_o, // error
  input wire logic fault_pin_i, // fault pin
  input wire logic debug_stall_i, // stall
  input wire logic counter_zero_i, // counter zero
  input wire logic commit_apply_o, // apply pulse
  input wire logic counter_reset_o, // reset pulse
  input wire logic fault_cond_o // fault level
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("no answer");
  a_err_unmapped: assert property (wb_err_o |-> !wb_ack_o && wb_adr_i[5:2] > 4'h8)
    else $error("bad err");
  a_resync_cause: assert property (counter_reset_o |-> wb_ack_o && wb_we_i &&
    wb_adr_i[5:2] == 4'h1) else $error("stray counter reset");
  a_resync_pulse: assert property (counter_reset_o |=> !counter_reset_o)
    else $error("reset pulse long");
  a_commit_zero: assert property (commit_apply_o |-> $past(counter_zero_i))
    else $error("apply off zero");
  a_commit_once: assert property (commit_apply_o |=> !commit_apply_o)
    else $error("apply repeated");
  a_stall_fault: assert property (debug_stall_i |=> fault_cond_o)
    else $error("stall not fault");
  a_pin_fault: assert property (fault_pin_i [*3] |=> fault_cond_o)
    else $error("pin not fault");
endmodule
bind pmc_master_ctrl pmc_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .fault_pin_i(fault_pin_i), .debug_stall_i(debug_stall_i),
  .counter_zero_i(counter_zero_i), .commit_apply_o(commit_apply_o),
  .counter_reset_o(counter_reset_o), .fault_cond_o(fault_cond_o));

// >>> tb/tb.sv
// self-checking bench for the pwm master control block
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] dat = 32'h0;
  logic fpin = 1'b0;
  logic stall = 1'b0;
  logic run = 1'b1;
  logic ireq = 1'b0;
  logic [31:0] rdat, r;
  logic ack, err, e, wa, wb2, cz, gint, capp, crst, fcond, pa, pb, mint;
  logic [1:0] w;
  int errors = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  int i;
  initial forever #2.5 clk_i = ~clk_i;
  pmc_master_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .fault_pin_i(fpin), .debug_stall_i(stall),
    .waveform_a_i(wa), .waveform_b_i(wb2), .generator_int_i(gint), .counter_zero_i(cz),
    .commit_apply_o(capp), .counter_reset_o(crst), .fault_cond_o(fcond),
    .waveform_out_a_o(pa), .waveform_out_b_o(pb), .module_int_o(mint));
  pmc_gen_model u_gen (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .counter_reset_i(crst),
    .int_req_i(ireq), .wave_a_o(wa), .wave_b_o(wb2), .zero_o(cz), .int_o(gint));
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("Error at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wbx(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && err !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) errors++;
    r = rdat;
    e = err;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wbx(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] x);
    wbx(1'b0, a, 32'h0);
    cmp(r, x);
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 9; i++) rd(6'(4 * i), 32'h0);
    wbx(1'b0, 6'h24, 32'h0);
    cmp({31'h0, e}, 32'h1);
    wr(6'h18, 32'h1_0001);
    rd(6'h18, 32'h0);
    $display("test regs done");
    for (i = 0; i < 16; i++) begin
      wr(6'h08, {30'h0, i[1:0]});
      wr(6'h0c, {30'h0, {2{i[2]}}});
      wr(6'h10, 32'h1);
      stall <= i[3];
      repeat (4) @(posedge clk_i);
      #1 w = {wb2, wa};
      @(posedge clk_i);
      #1 cmp({pb, pa}, ((w & i[1:0]) & ~{1'b0, i[3]}) ^ {2{i[2]}});
      cmp({31'h0, fcond}, {31'h0, i[3]});
      @(posedge clk_i);
      rd(6'h08, {30'h0, i[1:0]});
    end
    stall <= 1'b0;
    $display("test pins done");
    wr(6'h04, 32'h1);
    rd(6'h04, 32'h0);
    run <= 1'b0;
    @(posedge clk_i);
    if (cz === 1'b1) begin
      run <= 1'b1;
      @(posedge clk_i);
      run <= 1'b0;
    end
    wr(6'h00, 32'h1);
    rd(6'h00, 32'h1);
    wr(6'h00, 32'h0);
    rd(6'h00, 32'h1);
    run <= 1'b1;
    i = 0;
    while (capp !== 1'b1 && i < 12) begin
      @(posedge clk_i);
      i++;
    end
    cmp({31'h0, capp}, 32'h1);
    rd(6'h00, 32'h0);
    $display("test commit done");
    wr(6'h14, 32'h1_0001);
    ireq <= 1'b1;
    rd(6'h18, 32'h1);
    cmp({31'h0, mint}, 32'h1);
    ireq <= 1'b0;
    rd(6'h18, 32'h0);
    fpin <= 1'b1;
    repeat (4) @(posedge clk_i);
    fpin <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(6'h18, 32'h1_0000);
    cmp({31'h0, mint}, 32'h1);
    wr(6'h1c, 32'h0);
    rd(6'h18, 32'h1_0000);
    wr(6'h1c, 32'h1_0000);
    rd(6'h18, 32'h0);
    wr(6'h14, 32'h0);
    ireq <= 1'b1;
    rd(6'h18, 32'h1);
    cmp({31'h0, mint}, 32'h0);
    $display("test irq done");
    close_out();
  end
endmodule
